// >>> logic/loco_speed_ctrl.sv
// address matching, protocol gating, speed curve and ramp of the decoder
//
// What this block does
// - trinary base address is the short address variable 1.
// - all enabled protocols are accepted at once, no mode selection; the DCC-only variant accepts DCC alone.
// - trinary base+1..+3 drive function groups F5-F8, F9-F12, F13-F16.
// - speed and direction only from the base address.
// - consecutive count is {variable 49 bit 7, bit 3}.
// - variable 49 holds 19 after reset.
// - consecutive addresses only match trinary packets.
// - auto-registering address set by station only, no user read or write.
// - variable 47 bits 0..3 enable each track protocol, except in the DCC-only variant, which ignores them.
// - variable 47 holds 15 after reset.
// - writing variable 47 keeps the carrying protocol enabled.
// - programmer port works whatever variable 47 holds.
// - acceleration variable 3, deceleration variable 4, 0..63, time per step.
// - a function switch bypasses the ramps.
// - shunting scales speed by the trim in variable 101.
// - 14, 28 or 128 step commands map onto 256 levels.
// - minimum speed variable 2, maximum speed variable 5.
// - 28 curve points in 67..94, ends fixed 1 and 255, used unless DCC-only with variable 29 bit 4 clear.
// - curve is scaled between minimum and maximum speed.
// - DCC-only variant uses three-point table when variable 29 bit 4 clear.
// - DC section with matching polarity follows analogue voltage.
// - mismatch stops with ramp if DC brake set, else reverses.
// - AC section keeps direction, follows analogue voltage.
// - DC brake mode is variable 27 bit 3.
// - variable 29 bit 5 selects short or long address.
`timescale 1ns/10ps
module loco_speed_ctrl #(
  parameter int RAMP_CYC = loco_pkg::RAMP_UNIT_CYC,
  parameter bit DCC_ONLY = 1'b0
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // decoded track packet
  input wire logic pkt_valid_i,
  input wire loco_pkg::proto_type pkt_proto_i,
  input wire loco_pkg::kind_type pkt_kind_i,
  input wire logic pkt_long_i,
  input wire logic [13:0] pkt_addr_i,
  input wire logic pkt_dir_i,
  input wire loco_pkg::steps_type pkt_steps_i,
  input wire logic [7:0] pkt_speed_i,
  input wire logic [1:0] pkt_fgrp_i,
  input wire logic [4:0] pkt_fbits_i,
  input wire logic [9:0] pkt_cv_i,
  input wire logic [7:0] pkt_data_i,
  // dedicated programmer port
  input wire logic prog_we_i,
  input wire logic prog_re_i,
  input wire logic [9:0] prog_cv_i,
  input wire logic [7:0] prog_wdata_i,
  output logic [7:0] prog_rdata_o,
  output logic prog_rvalid_o,
  // auto-registering address assignment
  input wire logic reg_assign_i,
  input wire logic [13:0] reg_addr_i,
  // analogue track sense
  input wire logic dc_sense_i,
  input wire logic ac_sense_i,
  input wire logic dc_polarity_i,
  input wire logic [7:0] analog_level_i,
  // motor and functions
  output logic [7:0] motor_set_o,
  output logic dir_o,
  output logic [16:0] fn_o
);
  import loco_pkg::*;

  typedef struct packed {
    logic [CV_DEPTH-1:0][7:0] cv;
    logic [16:0] fn;
    logic dir;
    logic [7:0] lvl;
    logic [7:0] cur;
    logic [15:0] pre;
    logic [5:0] stp;
    amode_type amode;
    logic reg_ok;
    logic [13:0] reg_addr;
    logic [7:0] rdata;
    logic rvalid;
    logic dc_m, dc_s, dc_p, ac_m, ac_s, ac_p, pol_m, pol_s;
  } state_type;

  state_type st_ff, nxt_st;

  // default curve point, straight line between the fixed ends
  function automatic logic [7:0] curve_init(input int i);
    return 8'(1 + (i * 254) / 27);
  endfunction : curve_init

  // speed step to internal level
  function automatic logic [7:0] to_level(input steps_type s, input logic [7:0] sp);
    int p;
    p = int'(sp) * 255;
    case (s)
      STEPS_14: p = p / 14;
      STEPS_28: p = p / 28;
      default: p = p / 126;
    endcase
    return (p > 255) ? 8'hFF : 8'(p);
  endfunction : to_level

  logic accept, is_base, is_ext, prog_ok;
  logic [1:0] consec;
  logic [7:0] tgt, curve_v, cv47_wr;
  logic [5:0] rate;
  int off, idx, frac, v, lo, hi, vmin, vmax, vmid, s;

  // packet address match and protocol gate
  always_comb begin
    consec = {st_ff.cv[CV_LEGACY_CFG][CONSEC_HI_BIT], st_ff.cv[CV_LEGACY_CFG][CONSEC_LO_BIT]};
    off = int'(pkt_addr_i) - int'(st_ff.cv[CV_SHORT_ADDR]);
    accept = pkt_valid_i && (DCC_ONLY ? (pkt_proto_i == PROTO_DCC) : st_ff.cv[CV_PROTO_EN][pkt_proto_i]);
    is_ext = 1'b0;
    case (pkt_proto_i)
      PROTO_DCC: begin
        if (st_ff.cv[CV_CONFIG][LONG_BIT]) begin
          is_base = pkt_long_i && pkt_addr_i == {st_ff.cv[CV_LONG_HI][5:0], st_ff.cv[CV_LONG_LO]};
        end else begin
          is_base = !pkt_long_i && pkt_addr_i == {6'h00, st_ff.cv[CV_SHORT_ADDR]};
        end
      end
      PROTO_TRINARY: begin
        is_base = off == 0;
        is_ext = off >= 1 && off <= int'(consec);
      end
      PROTO_AUTOREG: is_base = st_ff.reg_ok && pkt_addr_i == st_ff.reg_addr;
      default: is_base = pkt_addr_i == {6'h00, st_ff.cv[CV_SHORT_ADDR]};
    endcase
    prog_ok = prog_cv_i < 10'(CV_DEPTH);
    cv47_wr = pkt_data_i | (8'h01 << pkt_proto_i);
  end

  // speed curve with interpolation, scaling, table and shunting
  always_comb begin
    idx = ((int'(st_ff.lvl) - 1) * 27) / 254;
    frac = ((int'(st_ff.lvl) - 1) * 27) % 254;
    lo = int'(st_ff.cv[int'(CV_CURVE_FIRST) + idx]);
    hi = (idx < CURVE_POINTS - 1) ? int'(st_ff.cv[int'(CV_CURVE_FIRST) + idx + 1]) : lo;
    v = lo + ((hi - lo) * frac) / 254;
    vmin = int'(st_ff.cv[CV_VMIN]);
    vmax = int'(st_ff.cv[CV_VMAX]);
    vmid = int'(st_ff.cv[CV_VMID]);
    if (DCC_ONLY && !st_ff.cv[CV_CONFIG][TABLE_BIT]) begin
      if (st_ff.lvl <= 8'h80) begin
        s = vmin + ((vmid - vmin) * int'(st_ff.lvl)) / 128;
      end else begin
        s = vmid + ((vmax - vmid) * (int'(st_ff.lvl) - 128)) / 127;
      end
    end else begin
      s = vmin + (v * (vmax - vmin)) / 255;
    end
    if (st_ff.fn[SHUNT_FN]) begin
      s = (s * int'(st_ff.cv[CV_SHUNT_TRIM])) / 255;
    end
    if (s < 0) s = 0;
    if (s > 255) s = 255;
    curve_v = (st_ff.lvl == 8'h00) ? 8'h00 : 8'(s);
    case (st_ff.amode)
      AN_FOLLOW: tgt = analog_level_i;
      AN_BRAKE: tgt = 8'h00;
      default: tgt = curve_v;
    endcase
    rate = (tgt > st_ff.cur) ? st_ff.cv[CV_ACCEL][5:0] : st_ff.cv[CV_DECEL][5:0];
  end

  // next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rvalid = 1'b0;
    // two-stage synchronisers and edge history
    nxt_st.dc_m = dc_sense_i;
    nxt_st.dc_s = st_ff.dc_m;
    nxt_st.dc_p = st_ff.dc_s;
    nxt_st.ac_m = ac_sense_i;
    nxt_st.ac_s = st_ff.ac_m;
    nxt_st.ac_p = st_ff.ac_s;
    nxt_st.pol_m = dc_polarity_i;
    nxt_st.pol_s = st_ff.pol_m;
    // station assigns the auto-registering address
    if (reg_assign_i) begin
      nxt_st.reg_ok = 1'b1;
      nxt_st.reg_addr = reg_addr_i;
    end
    // track packets
    if (accept && (is_base || is_ext)) begin
      case (pkt_kind_i)
        KIND_SPEED: begin
          if (is_base && st_ff.amode == AN_OFF) begin
            nxt_st.lvl = to_level(pkt_steps_i, pkt_speed_i);
            nxt_st.dir = pkt_dir_i;
          end
        end
        KIND_FUNC: begin
          case (is_ext ? 2'(off) : pkt_fgrp_i)
            2'h0: nxt_st.fn[4:0] = pkt_fbits_i;
            2'h1: nxt_st.fn[8:5] = pkt_fbits_i[3:0];
            2'h2: nxt_st.fn[12:9] = pkt_fbits_i[3:0];
            default: nxt_st.fn[16:13] = pkt_fbits_i[3:0];
          endcase
        end
        KIND_CV_WRITE: begin
          if (is_base && pkt_cv_i < 10'(CV_DEPTH)) begin
            if (pkt_cv_i[6:0] == CV_PROTO_EN) begin
              nxt_st.cv[CV_PROTO_EN] = cv47_wr;
            end else begin
              nxt_st.cv[pkt_cv_i[6:0]] = pkt_data_i;
            end
          end
        end
        default: ;
      endcase
    end
    // programmer port ignores the protocol enables
    if (prog_we_i && prog_ok) begin
      nxt_st.cv[prog_cv_i[6:0]] = prog_wdata_i;
    end
    if (prog_re_i) begin
      nxt_st.rdata = prog_ok ? st_ff.cv[prog_cv_i[6:0]] : 8'h00;
      nxt_st.rvalid = 1'b1;
    end
    nxt_st.cv[CV_CURVE_FIRST] = CURVE_FIRST_VAL;
    nxt_st.cv[CV_CURVE_LAST] = CURVE_LAST_VAL;
    // analogue section handling
    case (st_ff.amode)
      AN_OFF: begin
        if (st_ff.dc_s && !st_ff.dc_p) begin
          if (st_ff.pol_s == st_ff.dir) begin
            nxt_st.amode = AN_FOLLOW;
          end else if (st_ff.cv[CV_BRAKE_CFG][DC_BRAKE_BIT]) begin
            nxt_st.amode = AN_BRAKE;
          end else begin
            nxt_st.amode = AN_FOLLOW;
            nxt_st.dir = !st_ff.dir;
          end
        end else if (st_ff.ac_s && !st_ff.ac_p) begin
          nxt_st.amode = AN_FOLLOW;
        end
      end
      AN_FOLLOW, AN_BRAKE: begin
        if (!st_ff.dc_s && !st_ff.ac_s) nxt_st.amode = AN_OFF;
      end
      default: nxt_st.amode = AN_OFF;
    endcase
    // acceleration and deceleration ramp
    if (st_ff.fn[BYPASS_FN] || rate == 6'h00) begin
      nxt_st.cur = tgt;
      nxt_st.pre = 16'h0000;
      nxt_st.stp = 6'h00;
    end else if (st_ff.pre >= 16'(RAMP_CYC - 1)) begin
      nxt_st.pre = 16'h0000;
      if (st_ff.stp + 6'h01 >= rate) begin
        nxt_st.stp = 6'h00;
        if (tgt > st_ff.cur) nxt_st.cur = st_ff.cur + 8'h01;
        else if (tgt < st_ff.cur) nxt_st.cur = st_ff.cur - 8'h01;
      end else begin
        nxt_st.stp = st_ff.stp + 6'h01;
      end
    end else begin
      nxt_st.pre = st_ff.pre + 16'h0001;
    end
    // factory values
    if (sys_rst_i) begin
      nxt_st = '0;
      nxt_st.amode = AN_OFF;
      for (int i = 0; i < CURVE_POINTS; i++) begin
        nxt_st.cv[int'(CV_CURVE_FIRST) + i] = curve_init(i);
      end
      nxt_st.cv[CV_SHORT_ADDR] = SHORT_ADDR_RST;
      nxt_st.cv[CV_VMIN] = VMIN_RST;
      nxt_st.cv[CV_ACCEL] = ACCEL_RST;
      nxt_st.cv[CV_DECEL] = DECEL_RST;
      nxt_st.cv[CV_VMAX] = VMAX_RST;
      nxt_st.cv[CV_VMID] = VMID_RST;
      nxt_st.cv[CV_PROTO_EN] = PROTO_EN_RST;
      nxt_st.cv[CV_LEGACY_CFG] = LEGACY_CFG_RST;
      nxt_st.cv[CV_SHUNT_TRIM] = SHUNT_TRIM_RST;
    end
  end

  // state register
  always_ff @(posedge mclk_i) begin
    st_ff <= nxt_st;
  end

  // outputs
  assign motor_set_o = st_ff.cur;
  assign dir_o = st_ff.dir;
  assign fn_o = st_ff.fn;
  assign prog_rdata_o = st_ff.rdata;
  assign prog_rvalid_o = st_ff.rvalid;

  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  sequence dc_entry_s;
    st_ff.amode == AN_OFF && st_ff.dc_s && !st_ff.dc_p && st_ff.pol_s != st_ff.dir;
  endsequence

  a_proto_en_rst: assert property ($past(sys_rst_i) |-> st_ff.cv[CV_PROTO_EN] == 8'h0F)
    else $error("protocol enable not 15 after reset");
  a_legacy_rst: assert property ($past(sys_rst_i) |-> st_ff.cv[CV_LEGACY_CFG] == 8'h13)
    else $error("legacy config not 19 after reset");
  a_proto_gate: assert property (pkt_valid_i && pkt_kind_i == KIND_SPEED
      && !st_ff.cv[CV_PROTO_EN][pkt_proto_i] |=> $stable(st_ff.lvl))
    else $error("disabled protocol changed speed");
  a_enable_kept: assert property (accept && is_base && pkt_kind_i == KIND_CV_WRITE
      && pkt_cv_i == 10'h02F && !prog_we_i |=> st_ff.cv[CV_PROTO_EN][$past(pkt_proto_i)])
    else $error("carrying protocol was disabled");
  a_curve_ends: assert property (st_ff.cv[CV_CURVE_FIRST] == 8'h01
      && st_ff.cv[CV_CURVE_LAST] == 8'hFF)
    else $error("curve end points changed");
  a_consec_nospeed: assert property (pkt_valid_i && pkt_proto_i == PROTO_TRINARY
      && pkt_kind_i == KIND_SPEED && off >= 1 |=> $stable(st_ff.lvl))
    else $error("consecutive address changed speed");
  a_ramp_step: assert property (!st_ff.fn[BYPASS_FN] && rate != 6'h00 && $stable(rate)
      |=> (st_ff.cur - $past(st_ff.cur)) inside {8'h00, 8'h01, 8'hFF})
    else $error("ramp moved more than one level");
  a_dc_brake: assert property (dc_entry_s ##0 st_ff.cv[CV_BRAKE_CFG][DC_BRAKE_BIT]
      |=> st_ff.amode == AN_BRAKE && $stable(st_ff.dir))
    else $error("mismatched DC entry did not brake");
  a_dc_reverse: assert property (dc_entry_s ##0 !st_ff.cv[CV_BRAKE_CFG][DC_BRAKE_BIT]
      |=> st_ff.amode == AN_FOLLOW && st_ff.dir != $past(st_ff.dir))
    else $error("mismatched DC entry did not reverse");
endmodule : loco_speed_ctrl

// >>> logic/loco_pkg.sv
// constants and types of the locomotive address and speed control block
package loco_pkg;
  // clock and ramp timing
  localparam int CLK_MHZ = 10;
  localparam int RAMP_UNIT_US = 1000;
  localparam int RAMP_UNIT_CYC = RAMP_UNIT_US * CLK_MHZ;
  localparam int CV_DEPTH = 128;
  localparam int CURVE_POINTS = 28;
  // configuration variable numbers
  localparam logic [6:0] CV_SHORT_ADDR = 7'h01;
  localparam logic [6:0] CV_VMIN = 7'h02;
  localparam logic [6:0] CV_ACCEL = 7'h03;
  localparam logic [6:0] CV_DECEL = 7'h04;
  localparam logic [6:0] CV_VMAX = 7'h05;
  localparam logic [6:0] CV_VMID = 7'h06;
  localparam logic [6:0] CV_LONG_HI = 7'h11;
  localparam logic [6:0] CV_LONG_LO = 7'h12;
  localparam logic [6:0] CV_BRAKE_CFG = 7'h1B;
  localparam logic [6:0] CV_CONFIG = 7'h1D;
  localparam logic [6:0] CV_PROTO_EN = 7'h2F;
  localparam logic [6:0] CV_LEGACY_CFG = 7'h31;
  localparam logic [6:0] CV_CURVE_FIRST = 7'h43;
  localparam logic [6:0] CV_CURVE_LAST = 7'h5E;
  localparam logic [6:0] CV_SHUNT_TRIM = 7'h65;
  // bit positions
  localparam int DC_BRAKE_BIT = 3;
  localparam int TABLE_BIT = 4;
  localparam int LONG_BIT = 5;
  localparam int CONSEC_HI_BIT = 7;
  localparam int CONSEC_LO_BIT = 3;
  // values after reset
  localparam logic [7:0] PROTO_EN_RST = 8'h0F;
  localparam logic [7:0] LEGACY_CFG_RST = 8'h13;
  localparam logic [7:0] CURVE_FIRST_VAL = 8'h01;
  localparam logic [7:0] CURVE_LAST_VAL = 8'hFF;
  localparam logic [7:0] SHUNT_TRIM_RST = 8'h80;
  localparam logic [7:0] SHORT_ADDR_RST = 8'h03;
  localparam logic [7:0] VMIN_RST = 8'h01;
  localparam logic [7:0] VMID_RST = 8'h80;
  localparam logic [7:0] VMAX_RST = 8'hFF;
  localparam logic [7:0] ACCEL_RST = 8'h02;
  localparam logic [7:0] DECEL_RST = 8'h02;
  // function numbers of the ramp bypass and shunting switches
  localparam logic [4:0] BYPASS_FN = 5'h03;
  localparam logic [4:0] SHUNT_FN = 5'h04;
  // enumerations
  typedef enum logic [1:0] {
    PROTO_DCC = 2'b00, PROTO_AUTOREG = 2'b01, PROTO_TRINARY = 2'b10, PROTO_FOURTH = 2'b11
  } proto_type;
  typedef enum logic [1:0] {
    KIND_SPEED = 2'b00, KIND_FUNC = 2'b01, KIND_CV_WRITE = 2'b10, KIND_IDLE = 2'b11
  } kind_type;
  typedef enum logic [1:0] {
    STEPS_14 = 2'b00, STEPS_28 = 2'b01, STEPS_128 = 2'b10
  } steps_type;
  typedef enum logic [1:0] {
    AN_OFF = 2'b00, AN_FOLLOW = 2'b01, AN_BRAKE = 2'b10
  } amode_type;
endpackage : loco_pkg

// >>> test/loco_station.sv
// command station model that sends decoded track packets
`timescale 1ns/10ps
module loco_station (
  // clock
  input wire logic mclk_i,
  // packet towards the decoder
  output logic pkt_valid_o,
  output loco_pkg::proto_type pkt_proto_o,
  output loco_pkg::kind_type pkt_kind_o,
  output logic [13:0] pkt_addr_o,
  output logic pkt_dir_o,
  output loco_pkg::steps_type pkt_steps_o,
  output logic [7:0] pkt_speed_o,
  output logic [1:0] pkt_fgrp_o,
  output logic [4:0] pkt_fbits_o,
  output logic [9:0] pkt_cv_o,
  output logic [7:0] pkt_data_o,
  // address assignment at registration
  output logic reg_assign_o,
  output logic [13:0] reg_addr_o
);
  import loco_pkg::*;
  // quiet lines at time zero
  initial begin
    pkt_valid_o = 1'b0;
    reg_assign_o = 1'b0;
    reg_addr_o = 14'h0000;
  end
  // one packet: c carries steps and direction, group or cv number
  task automatic send(input proto_type p, input kind_type k, input logic [13:0] a,
                      input logic [9:0] c, input logic [7:0] x);
    @(posedge mclk_i);
    pkt_valid_o <= 1'b1;
    pkt_proto_o <= p;
    pkt_kind_o <= k;
    pkt_addr_o <= a;
    pkt_dir_o <= c[2];
    pkt_steps_o <= steps_type'(c[1:0]);
    pkt_speed_o <= x;
    pkt_fgrp_o <= c[1:0];
    pkt_fbits_o <= x[4:0];
    pkt_cv_o <= c;
    pkt_data_o <= x;
    @(posedge mclk_i);
    pkt_valid_o <= 1'b0;
    // released address, speed and data fields no longer hold the last value
    pkt_addr_o <= ~a;
    pkt_speed_o <= ~x;
    pkt_data_o <= ~x;
  endtask : send
  // station hands out the registration address, no user path
  task automatic register_addr(input logic [13:0] a);
    @(posedge mclk_i);
    reg_assign_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge mclk_i);
    reg_assign_o <= 1'b0;
  endtask : register_addr
endmodule : loco_station

// >>> test/tb_loco_speed_ctrl.sv
// self-checking bench of the locomotive address and speed control block
`timescale 1ns/10ps
module tb_loco_speed_ctrl;
  import loco_pkg::*;
  logic mclk_i, sys_rst_i, prog_we_i, prog_re_i, dc_sense_i, ac_sense_i, dc_polarity_i;
  logic [9:0] prog_cv_i, pkt_cv;
  logic [7:0] prog_wdata_i, analog_level_i, prog_rdata_o, motor_set_o, pkt_speed, pkt_data, fb;
  logic prog_rvalid_o, dir_o, pkt_valid, pkt_dir, reg_assign, pkt_long;
  logic [16:0] fn_o;
  logic [13:0] pkt_addr, reg_addr;
  logic [1:0] pkt_fgrp;
  logic [4:0] pkt_fbits;
  proto_type pkt_proto;
  kind_type pkt_kind;
  steps_type pkt_steps;
  logic [7:0] exp_q[$];
  logic [7:0] stp[3] = '{8'h0E, 8'h1C, 8'h7E};
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  loco_station station (.mclk_i(mclk_i), .pkt_valid_o(pkt_valid), .pkt_proto_o(pkt_proto),
    .pkt_kind_o(pkt_kind), .pkt_addr_o(pkt_addr), .pkt_dir_o(pkt_dir), .pkt_steps_o(pkt_steps),
    .pkt_speed_o(pkt_speed), .pkt_fgrp_o(pkt_fgrp), .pkt_fbits_o(pkt_fbits), .pkt_cv_o(pkt_cv),
    .pkt_data_o(pkt_data), .reg_assign_o(reg_assign), .reg_addr_o(reg_addr));
  loco_speed_ctrl #(.RAMP_CYC(4)) DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .pkt_valid_i(pkt_valid), .pkt_proto_i(pkt_proto), .pkt_kind_i(pkt_kind), .pkt_long_i(pkt_long),
    .pkt_addr_i(pkt_addr), .pkt_dir_i(pkt_dir), .pkt_steps_i(pkt_steps),
    .pkt_speed_i(pkt_speed), .pkt_fgrp_i(pkt_fgrp), .pkt_fbits_i(pkt_fbits), .pkt_cv_i(pkt_cv),
    .pkt_data_i(pkt_data), .prog_we_i(prog_we_i), .prog_re_i(prog_re_i), .prog_cv_i(prog_cv_i),
    .prog_wdata_i(prog_wdata_i), .prog_rdata_o(prog_rdata_o), .prog_rvalid_o(prog_rvalid_o),
    .reg_assign_i(reg_assign), .reg_addr_i(reg_addr), .dc_sense_i(dc_sense_i),
    .ac_sense_i(ac_sense_i), .dc_polarity_i(dc_polarity_i), .analog_level_i(analog_level_i),
    .motor_set_o(motor_set_o), .dir_o(dir_o), .fn_o(fn_o));
  // compare and count
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    if (n_mismatch == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict
  task automatic waitc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : waitc
  // programmer port cycles, reads note their expectation
  task automatic prog_wr(input logic [9:0] c, input logic [7:0] d);
    @(posedge mclk_i);
    prog_we_i <= 1'b1;
    prog_cv_i <= c;
    prog_wdata_i <= d;
    @(posedge mclk_i);
    prog_we_i <= 1'b0;
  endtask : prog_wr
  task automatic prog_rd(input logic [9:0] c, input logic [7:0] e);
    exp_q.push_back(e);
    @(posedge mclk_i);
    prog_re_i <= 1'b1;
    prog_cv_i <= c;
    @(posedge mclk_i);
    prog_re_i <= 1'b0;
    waitc(2);
  endtask : prog_rd
  // clock
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  // watcher takes the oldest read note at each read answer
  always @(posedge mclk_i) begin
    if (prog_rvalid_o === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(17'h1, 17'h0);
      end else begin
        check(prog_rdata_o, exp_q.pop_front());
      end
    end
  end
  // hang guard
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // main sequence
  initial begin
    sys_rst_i = 1'b1;
    {prog_we_i, prog_re_i, dc_sense_i, ac_sense_i, dc_polarity_i} = 5'h00;
    prog_cv_i = 10'h000;
    pkt_long = 1'b0;
    prog_wdata_i = 8'h00;
    analog_level_i = 8'h00;
    void'($urandom(32'h538047C5));
    waitc(16);
    sys_rst_i <= 1'b0;
    station.register_addr(14'h0105);
    prog_rd(10'h02F, 8'h0F);
    prog_rd(10'h031, 8'h13);
    prog_rd(10'h080, 8'h00);
    prog_wr(10'h003, 8'h00);
    prog_wr(10'h004, 8'h00);
    fb = 8'($urandom_range(7));
    station.send(PROTO_TRINARY, KIND_FUNC, 14'h0003, 10'h000, fb);
    waitc(3);
    check(fn_o[4:0], fb[4:0]);
    fb = 8'($urandom_range(7));
    station.send(PROTO_DCC, KIND_FUNC, 14'h0003, 10'h000, fb);
    waitc(3);
    check(fn_o[4:0], fb[4:0]);
    station.send(PROTO_TRINARY, KIND_FUNC, 14'h0004, 10'h000, 8'h0F);
    waitc(3);
    check(fn_o[8:5], 4'h0);
    prog_wr(10'h031, 8'h93);
    for (int i = 1; i <= 3; i++) begin
      fb = 8'($urandom_range(15, 1));
      station.send(PROTO_TRINARY, KIND_FUNC, 14'(3 + i), 10'h000, fb);
      waitc(3);
      check(fn_o[4*i+1 +: 4], (i < 3) ? fb[3:0] : 4'h0);
    end
    fb = {4'h0, fn_o[8:5]};
    station.send(PROTO_DCC, KIND_FUNC, 14'h0004, 10'h001, 8'h00);
    waitc(3);
    check(fn_o[8:5], fb[3:0]);
    for (int s = 0; s < 3; s++) begin
      station.send(PROTO_DCC, KIND_SPEED, 14'h0003, 10'(4 + s), stp[s]);
      waitc(5);
      check({dir_o, motor_set_o}, 9'h1FF);
    end
    station.send(PROTO_TRINARY, KIND_SPEED, 14'h0004, 10'h001, 8'h00);
    waitc(5);
    check(motor_set_o, 8'hFF);
    prog_wr(10'h005, 8'h80);
    waitc(5);
    check(motor_set_o, 8'h80);
    prog_wr(10'h005, 8'hFF);
    station.send(PROTO_TRINARY, KIND_FUNC, 14'h0003, 10'h000, 8'h10);
    waitc(5);
    check(motor_set_o > 8'h70 && motor_set_o < 8'h90, 1'b1);
    station.send(PROTO_DCC, KIND_SPEED, 14'h0003, 10'h005, 8'h00);
    prog_wr(10'h003, 8'h02);
    station.send(PROTO_TRINARY, KIND_FUNC, 14'h0003, 10'h000, 8'h00);
    station.send(PROTO_DCC, KIND_SPEED, 14'h0003, 10'h005, 8'h1C);
    waitc(10);
    check(motor_set_o <= 8'h06, 1'b1);
    station.send(PROTO_TRINARY, KIND_FUNC, 14'h0003, 10'h000, 8'h08);
    waitc(4);
    check(motor_set_o, 8'hFF);
    station.send(PROTO_TRINARY, KIND_FUNC, 14'h0003, 10'h000, 8'h00);
    prog_wr(10'h003, 8'h00);
    station.send(PROTO_DCC, KIND_CV_WRITE, 14'h0003, 10'h02F, 8'h00);
    prog_rd(10'h02F, 8'h01);
    station.send(PROTO_TRINARY, KIND_FUNC, 14'h0003, 10'h000, 8'h07);
    waitc(3);
    check(fn_o[4:0], 5'h00);
    prog_wr(10'h02F, 8'h00);
    prog_rd(10'h02F, 8'h00);
    station.send(PROTO_DCC, KIND_FUNC, 14'h0003, 10'h000, 8'h07);
    waitc(3);
    check(fn_o[4:0], 5'h00);
    prog_wr(10'h02F, 8'h0F);
    // long address form only while variable 29 bit 5 is set
    prog_wr(10'h011, 8'h00);
    prog_wr(10'h012, 8'h80);
    prog_wr(10'h01D, 8'h20);
    pkt_long <= 1'b1;
    station.send(PROTO_DCC, KIND_FUNC, 14'h0080, 10'h000, 8'h05);
    waitc(3);
    check(fn_o[4:0], 5'h05);
    pkt_long <= 1'b0;
    station.send(PROTO_DCC, KIND_FUNC, 14'h0003, 10'h000, 8'h00);
    waitc(3);
    check(fn_o[4:0], 5'h05);
    prog_wr(10'h01D, 8'h00);
    station.send(PROTO_DCC, KIND_FUNC, 14'h0003, 10'h000, 8'h00);
    waitc(3);
    check(fn_o[4:0], 5'h00);
    analog_level_i <= 8'hFF;
    dc_polarity_i <= 1'b1;
    dc_sense_i <= 1'b1;
    waitc(8);
    check({dir_o, motor_set_o}, 9'h1FF);
    dc_sense_i <= 1'b0;
    waitc(6);
    dc_polarity_i <= 1'b0;
    dc_sense_i <= 1'b1;
    waitc(8);
    check(dir_o, 1'b0);
    dc_sense_i <= 1'b0;
    prog_wr(10'h01B, 8'h08);
    waitc(6);
    dc_polarity_i <= 1'b1;
    dc_sense_i <= 1'b1;
    waitc(8);
    check({dir_o, motor_set_o}, 9'h000);
    dc_sense_i <= 1'b0;
    waitc(6);
    ac_sense_i <= 1'b1;
    waitc(8);
    check(dir_o, 1'b0);
    ac_sense_i <= 1'b0;
    waitc(6);
    print_verdict();
  end
endmodule : tb_loco_speed_ctrl
